// file: bus_peer_model.sv
// peer cpu on the two-wire bus: sends one byte and collects one per frame
// serial clock seen as a level sampled on the system clock
`timescale 1ns/10ps
module bus_peer_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // bus
    input  wire logic       sck_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    // user side
    input  wire logic [7:0] tx_byte_i,
    output logic [7:0]      rx_byte_o
);
    logic       sck_q;
    logic [2:0] count;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sck_q <= 1'b1;
            count <= 3'h0;
            sda_o <= 1'b1;
            rx_byte_o <= 8'h00;
        end else begin
            sck_q <= sck_i;
            if (sck_q && !sck_i)
                sda_o <= tx_byte_i[3'h7 - count];
            if (!sck_q && sck_i) begin
                rx_byte_o <= {rx_byte_o[6:0], sda_i};
                count <= count + 3'h1;
                // let go after the eighth bit so the pull-up owns the line
                if (count == 3'h7)
                    sda_o <= 1'b1;
            end
        end
    end
endmodule

// file: serial_ctrl_props.sv
// port assertions for the serial transfer control block
// bound to the top module; one clock domain, async active-low reset
`timescale 1ns/10ps
module serial_ctrl_props (
    // clock and reset
    input wire logic        CLK_I,
    input wire logic        RST_B_I,
    // register bus
    input wire logic        AWVALID_I,
    input wire logic        AWREADY_O,
    input wire logic        WVALID_I,
    input wire logic        WREADY_O,
    input wire logic        BVALID_O,
    input wire logic        BREADY_I,
    input wire logic [15:0] ARADDR_I,
    input wire logic        ARVALID_I,
    input wire logic        ARREADY_O,
    input wire logic [31:0] RDATA_O,
    input wire logic [1:0]  RRESP_O,
    input wire logic        RVALID_O,
    input wire logic        RREADY_I,
    // pins
    input wire logic        BUS_A_OE_O,
    input wire logic        BUS_B_OE_O,
    input wire logic        VECTOR_PAGE_FLAG_I
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire ar_hs = ARVALID_I && ARREADY_O;
    pin_exclusive_a: assert property (!(BUS_A_OE_O && BUS_B_OE_O))
        else $error("both bus pins driven");
    wr_answer_a: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
        else $error("write response late");
    b_block_a: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
        else $error("write taken while response pending");
    b_release_a: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
        else $error("write response not released");
    ar_block_a: assert property (RVALID_O |-> !ARREADY_O)
        else $error("read taken while data pending");
    rd_answer_a: assert property (ar_hs |=> RVALID_O)
        else $error("read data late");
    r_release_a: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
        else $error("read data not released");
    unmapped_rd_a: assert property (ar_hs && ARADDR_I > sync_serial_pkg::ADDR_VECTOR
        |=> RRESP_O == 2'h2 && RDATA_O == 32'h0000_0000) else $error("unmapped read answered");
    vector_word_a: assert property (ar_hs && ARADDR_I == sync_serial_pkg::ADDR_VECTOR
        |=> RDATA_O == {16'hFE30, $past(VECTOR_PAGE_FLAG_I) ? 16'h8030 : 16'h0030})
        else $error("vector word wrong");
endmodule
bind sync_serial_bus_transfer_ctrl serial_ctrl_props i_serial_ctrl_props (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
    .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .BUS_A_OE_O(BUS_A_OE_O),
    .BUS_B_OE_O(BUS_B_OE_O), .VECTOR_PAGE_FLAG_I(VECTOR_PAGE_FLAG_I));

// file: sync_serial_bus_transfer_ctrl.sv
// serial channel 0 transfer control: shift register, enables, wake-up irq
// assumes an axi4-lite master on CLK_I; external serial clock synchronous to CLK_I
// Functional notes
// (R01) transmit enabled: shift write starts eight-bit send
// (R02) send msb first on serial clock falling edge
// (R03) after send, shift register zero, raise irq
// (R04) transmit off: receive enable rising starts reception
// (R05) receive enabled: shift read starts next reception
// (R06) no start on re-set or with transmit
// (R07) sample on rising edge, latch byte, irq
// (R08) both enabled: send and capture bus data
// (R09) vectors 0030H/8030H by page flag, word FE30H
// (R10) software picks pin and clock before enabling
// (R11) wake-up: irq only on address reception
// (R12) clock source: external, baud/2, div32, div8
// (R13) mode: 3-wire msb, 3-wire lsb, bus, prohibited
// (R14) pin select routes data, unused pin floats
// (R15) transmit off: data outputs high impedance
// (R16) irq flag set on eighth rising edge
// (R17) slave busy: start waits until ready
// (R18) count edges, end after eight bits
`timescale 1ns/10ps
module sync_serial_bus_transfer_ctrl (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    // axi4-lite write
    input  wire logic [15:0] AWADDR_I,
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    output logic [1:0]       BRESP_O,
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    // axi4-lite read
    input  wire logic [15:0] ARADDR_I,
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    // serial clock pin
    input  wire logic        SCK_I,
    output logic             SCK_O,
    output logic             SCK_OE_O,
    // bus data pins
    input  wire logic        BUS_A_I,
    output logic             BUS_A_O,
    output logic             BUS_A_OE_O,
    input  wire logic        BUS_B_I,
    output logic             BUS_B_O,
    output logic             BUS_B_OE_O,
    // system side
    input  wire logic        BAUD_TICK_I,
    input  wire logic        VECTOR_PAGE_FLAG_I,
    input  wire logic        SLAVE_BUSY_I,
    input  wire logic        ADDRESS_FRAME_I,
    output logic             IRQ_O
);
    typedef enum logic [1:0] {IDLE, WAIT_READY, SHIFT} xfer_state_t;

    xfer_state_t state;
    logic [7:0]  mode;
    logic [7:0]  shift;
    logic [3:0]  bit_count;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [4:0]  div_count;
    logic        int_clk;
    logic        baud_clk;
    logic        sck_prev;
    logic        data_out;
    logic        aw_held;
    logic        w_held;
    logic [15:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    logic [1:0]  clk_src;
    logic [1:0]  op_mode;
    logic        tx_en;
    logic        rx_en;
    logic        bus_mode;
    logic        sck_now;
    logic        sck_rise;
    logic        sck_fall;
    logic        do_write;
    logic        do_read;
    logic        mode_wr;
    logic        shift_wr;
    logic        shift_rd;
    logic        status_rd;
    logic        rx_rise_start;
    logic        start_req;
    logic        sample_in;
    logic        xfer_end;
    logic        done_event;
    logic [7:0]  next_mode;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign clk_src  = mode[sync_serial_pkg::BIT_CLS_HI:sync_serial_pkg::BIT_CLS_LO];
    assign op_mode  = mode[sync_serial_pkg::BIT_OPM_HI:sync_serial_pkg::BIT_OPM_LO];
    assign tx_en    = mode[sync_serial_pkg::BIT_TX_EN];
    assign rx_en    = mode[sync_serial_pkg::BIT_RX_EN];
    assign bus_mode = (op_mode == sync_serial_pkg::OPM_BUS_MSB);

    // bus slave: address and data taken in either order, one write at a time
    assign AWREADY_O = !aw_held && !BVALID_O;
    assign WREADY_O  = !w_held && !BVALID_O;
    assign do_write  = aw_held && w_held && !BVALID_O;
    assign ARREADY_O = !RVALID_O;
    assign do_read   = ARVALID_I && ARREADY_O;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 16'h0000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (AWVALID_I && AWREADY_O) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR_I;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (WVALID_I && WREADY_O) begin
                w_held <= 1'b1;
                w_data <= WDATA_I;
                w_strb <= WSTRB_I;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            BVALID_O <= 1'b0;
            BRESP_O  <= sync_serial_pkg::AXI_OKAY;
        end else if (do_write) begin
            BVALID_O <= 1'b1;
            BRESP_O  <= (aw_addr == sync_serial_pkg::ADDR_MODE || aw_addr ==
                         sync_serial_pkg::ADDR_SHIFT || aw_addr == sync_serial_pkg::ADDR_MASK)
                        ? sync_serial_pkg::AXI_OKAY : sync_serial_pkg::AXI_SLVERR;
        end else if (BREADY_I) begin
            BVALID_O <= 1'b0;
        end
    end

    assign mode_wr   = do_write && w_strb[0] && aw_addr == sync_serial_pkg::ADDR_MODE;
    assign shift_wr  = do_write && w_strb[0] && aw_addr == sync_serial_pkg::ADDR_SHIFT;
    assign shift_rd  = do_read && ARADDR_I == sync_serial_pkg::ADDR_SHIFT;
    assign status_rd = do_read && ARADDR_I == sync_serial_pkg::ADDR_STATUS;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (ARADDR_I)
            sync_serial_pkg::ADDR_MODE:   rd_word = {24'h00_0000, mode};
            sync_serial_pkg::ADDR_SHIFT:  rd_word = {24'h00_0000, shift};
            sync_serial_pkg::ADDR_STATUS: rd_word = {30'h0000_0000, status};
            sync_serial_pkg::ADDR_MASK:   rd_word = {30'h0000_0000, mask};
            sync_serial_pkg::ADDR_VECTOR: rd_word = {sync_serial_pkg::MACRO_WORD,
                                                     VECTOR_PAGE_FLAG_I
                                                     ? sync_serial_pkg::VEC_PAGE1
                                                     : sync_serial_pkg::VEC_PAGE0}; // R09
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            RVALID_O <= 1'b0;
            RDATA_O  <= 32'h0000_0000;
            RRESP_O  <= sync_serial_pkg::AXI_OKAY;
        end else if (do_read) begin
            RVALID_O <= 1'b1;
            RDATA_O  <= rd_word;
            RRESP_O  <= rd_hit ? sync_serial_pkg::AXI_OKAY : sync_serial_pkg::AXI_SLVERR;
        end else if (RREADY_I) begin
            RVALID_O <= 1'b0;
        end
    end

    // mode register; prohibited mode code is refused, other fields still take
    always_comb begin
        next_mode = w_data[7:0];
        if (next_mode[sync_serial_pkg::BIT_OPM_HI:sync_serial_pkg::BIT_OPM_LO] == 2'h3) begin
            next_mode[sync_serial_pkg::BIT_OPM_HI:sync_serial_pkg::BIT_OPM_LO] = op_mode; // R13
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mode <= sync_serial_pkg::MODE_RESET;
        end else if (mode_wr) begin
            mode <= next_mode;
        end
    end

    // internal serial clock generation, idles high between transfers
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            div_count <= 5'h00;
            int_clk   <= 1'b1;
            baud_clk  <= 1'b1;
        end else begin
            if (BAUD_TICK_I) begin
                baud_clk <= !baud_clk; // R12
            end
            if (state != SHIFT) begin
                div_count <= 5'h00;
                int_clk   <= 1'b1;
            end else if (div_count == (clk_src == sync_serial_pkg::CLS_DIV32
                         ? sync_serial_pkg::HALF_DIV32 : sync_serial_pkg::HALF_DIV8)) begin
                div_count <= 5'h00;
                int_clk   <= !int_clk; // R12
            end else begin
                div_count <= div_count + 5'h01;
            end
        end
    end

    always_comb begin
        case (clk_src)
            sync_serial_pkg::CLS_EXTERNAL:  sck_now = SCK_I;
            sync_serial_pkg::CLS_BAUD_HALF: sck_now = (state == SHIFT) ? baud_clk : 1'b1;
            default:                        sck_now = int_clk;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sck_prev <= 1'b1;
        end else begin
            sck_prev <= sck_now;
        end
    end

    assign sck_rise = sck_now && !sck_prev;
    assign sck_fall = !sck_now && sck_prev;
    assign SCK_O    = sck_now;
    assign SCK_OE_O = (clk_src != sync_serial_pkg::CLS_EXTERNAL); // R12

    // start conditions
    assign rx_rise_start = mode_wr && !tx_en && !next_mode[sync_serial_pkg::BIT_TX_EN]
                           && !rx_en && next_mode[sync_serial_pkg::BIT_RX_EN]; // R04 R06
    assign start_req = (shift_wr && tx_en) || rx_rise_start
                       || (shift_rd && rx_en); // R01 R05 R08
    assign xfer_end  = state == SHIFT && sck_rise && bit_count == sync_serial_pkg::BITS_PER_XFER - 4'h1;
    assign sample_in = rx_en ? (mode[sync_serial_pkg::BIT_PIN_SEL] ? BUS_B_I : BUS_A_I) : 1'b0;
    assign done_event = xfer_end && (!mode[sync_serial_pkg::BIT_WAKE] || !bus_mode
                        || ADDRESS_FRAME_I); // R11 R16

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state     <= IDLE;
            bit_count <= 4'h0;
        end else begin
            case (state)
                IDLE: if (start_req) begin
                    bit_count <= 4'h0;
                    state     <= SLAVE_BUSY_I ? WAIT_READY : SHIFT; // R17
                end
                WAIT_READY: if (!SLAVE_BUSY_I) begin
                    state <= SHIFT; // R17
                end
                SHIFT: if (sck_rise) begin
                    bit_count <= bit_count + 4'h1; // R18
                    if (xfer_end) begin
                        state <= IDLE; // R18
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    // shift register: software write, or one bit per rising edge
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            shift <= 8'h00;
        end else if (shift_wr && state == IDLE) begin
            shift <= w_data[7:0];
        end else if (state == SHIFT && sck_rise) begin
            if (op_mode == sync_serial_pkg::OPM_3W_LSB) begin
                shift <= {sample_in, shift[7:1]};
            end else begin
                shift <= {shift[6:0], sample_in}; // R07 R08 R03
            end
        end
    end

    // output bit changes on the falling edge; first bit follows the shift register while not shifting
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            data_out <= 1'b1;
        end else if (state != SHIFT) begin
            data_out <= (op_mode == sync_serial_pkg::OPM_3W_LSB) ? shift[0] : shift[7];
        end else if (sck_fall) begin
            data_out <= (op_mode == sync_serial_pkg::OPM_3W_LSB) ? shift[0] : shift[7]; // R02
        end
    end

    // unused pin and disabled transmitter float
    assign BUS_A_O    = data_out;
    assign BUS_B_O    = data_out;
    assign BUS_A_OE_O = tx_en && !mode[sync_serial_pkg::BIT_PIN_SEL]; // R14 R15
    assign BUS_B_OE_O = tx_en && mode[sync_serial_pkg::BIT_PIN_SEL]; // R14 R15

    // sticky status cleared by read; a same-cycle event wins
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            status <= 2'h0;
            mask   <= 2'h0;
        end else begin
            if (do_write && w_strb[0] && aw_addr == sync_serial_pkg::ADDR_MASK) begin
                mask <= w_data[1:0];
            end
            status[sync_serial_pkg::ST_DONE] <= done_event
                || (status[sync_serial_pkg::ST_DONE] && !status_rd); // R03 R07 R16
            status[sync_serial_pkg::ST_ADDR] <= (xfer_end && ADDRESS_FRAME_I)
                || (status[sync_serial_pkg::ST_ADDR] && !status_rd);
        end
    end

    assign IRQ_O = |(status & mask);
endmodule

// file: sync_serial_pkg.sv
// constants for the two-wire serial bus transfer control block
// used by the control block, its assertions and the testbench; no imports, scoped use
package sync_serial_pkg;
    // register byte addresses on the axi4-lite bus
    localparam logic [15:0] ADDR_MODE      = 16'hFF80;
    localparam logic [15:0] ADDR_SHIFT     = 16'hFF84;
    localparam logic [15:0] ADDR_STATUS    = 16'hFF88;
    localparam logic [15:0] ADDR_MASK      = 16'hFF8C;
    localparam logic [15:0] ADDR_VECTOR    = 16'hFF90;
    localparam logic [7:0]  MODE_RESET     = 8'h00;
    // mode register bit positions
    localparam int          BIT_TX_EN      = 7;
    localparam int          BIT_RX_EN      = 6;
    localparam int          BIT_WAKE       = 5;
    localparam int          BIT_PIN_SEL    = 4;
    localparam int          BIT_OPM_HI     = 3;
    localparam int          BIT_OPM_LO     = 2;
    localparam int          BIT_CLS_HI     = 1;
    localparam int          BIT_CLS_LO     = 0;
    // clock source codes
    localparam logic [1:0]  CLS_EXTERNAL   = 2'h0;
    localparam logic [1:0]  CLS_BAUD_HALF  = 2'h1;
    localparam logic [1:0]  CLS_DIV32      = 2'h2;
    localparam logic [1:0]  CLS_DIV8       = 2'h3;
    // operating mode codes
    localparam logic [1:0]  OPM_3W_MSB     = 2'h0;
    localparam logic [1:0]  OPM_3W_LSB     = 2'h1;
    localparam logic [1:0]  OPM_BUS_MSB    = 2'h2;
    // half period minus one, in system clocks, for the divided internal clocks
    localparam logic [4:0]  HALF_DIV32     = 5'h0F;
    localparam logic [4:0]  HALF_DIV8      = 5'h03;
    localparam logic [3:0]  BITS_PER_XFER  = 4'h8;
    // interrupt vector figures
    localparam logic [15:0] VEC_PAGE0      = 16'h0030;
    localparam logic [15:0] VEC_PAGE1      = 16'h8030;
    localparam logic [15:0] MACRO_WORD     = 16'hFE30;
    // status bits
    localparam int          ST_DONE        = 0;
    localparam int          ST_ADDR        = 1;
    localparam logic [1:0]  AXI_OKAY       = 2'h0;
    localparam logic [1:0]  AXI_SLVERR     = 2'h2;
endpackage

// file: testbench.sv
// self-checking bench: register bus driver, peer cpu on bus pin a
// pin a and the serial clock are pulled up when nobody drives them
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'b0, rst_b = 1'b0, page = 1'b0, addr_frame = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000, seed = 32'h644e_363d;
    logic [7:0]  peer_tx = 8'hFF, peer_rx, d, p;
    logic        awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, irq;
    logic        a_o, a_oe, b_o, b_oe, peer_sda;
    logic        busy = 1'b0;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] expq[$];
    int          mismatches = 0, check_count = 0, cycles = 0;
    wire         bus_a = (a_oe ? a_o : 1'b1) & peer_sda;
    wire         sck = sck_oe ? sck_o : 1'b1;
    sync_serial_bus_transfer_ctrl i_sync_serial_bus_transfer_ctrl (
        .CLK_I(clk), .RST_B_I(rst_b), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
        .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
        .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .SCK_I(1'b1), .SCK_O(sck_o),
        .SCK_OE_O(sck_oe), .BUS_A_I(bus_a), .BUS_A_O(a_o), .BUS_A_OE_O(a_oe), .BUS_B_I(1'b1),
        .BUS_B_O(b_o), .BUS_B_OE_O(b_oe), .BAUD_TICK_I(1'b0), .VECTOR_PAGE_FLAG_I(page),
        .SLAVE_BUSY_I(busy), .ADDRESS_FRAME_I(addr_frame), .IRQ_O(irq));
    bus_peer_model i_bus_peer_model (.clk_i(clk), .rst_b_i(rst_b), .sck_i(sck),
        .sda_i(bus_a), .sda_o(peer_sda), .tx_byte_i(peer_tx), .rx_byte_o(peer_rx));
    initial forever #2 clk = ~clk;
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [33:0] ok(input logic [7:0] v);
        return {26'h0, v};
    endfunction
    task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic [1:0] r);
        expq.push_back({r, 32'h0000_0000});
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [33:0] e);
        expq.push_back(e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic wait_irq;
        do @(posedge clk); while (irq !== 1'b1);
    endtask
    task automatic quiet;
        // long enough for a whole frame, so a wrong start would show
        repeat (200) @(posedge clk);
        check(34'(irq), 34'h0);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (bvalid && bready)
            check({bresp, 32'h0000_0000}, expq.pop_front());
        if (rvalid && rready)
            check({rresp, rdata}, expq.pop_front());
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd(16'hFF80, ok(8'h00));
        wr(sync_serial_pkg::ADDR_MASK, 8'h03, 2'h0);
        wr(16'hFF80, 8'h8B, 2'h0);
        seed = lfsr(seed);
        d = seed[7:0];
        wr(sync_serial_pkg::ADDR_SHIFT, d, 2'h0);
        wait_irq();
        check(34'(peer_rx), 34'(d));
        rd(sync_serial_pkg::ADDR_STATUS, ok(8'h01));
        rd(sync_serial_pkg::ADDR_SHIFT, ok(8'h00));
        wr(16'hFF80, 8'hCB, 2'h0);
        quiet();
        seed = lfsr(seed);
        p = seed[15:8];
        d = seed[7:0];
        peer_tx <= p;
        wr(sync_serial_pkg::ADDR_SHIFT, d, 2'h0);
        wait_irq();
        rd(sync_serial_pkg::ADDR_STATUS, ok(8'h01));
        wr(16'hFF80, 8'h0B, 2'h0);
        rd(sync_serial_pkg::ADDR_SHIFT, ok(d & p));
        seed = lfsr(seed);
        p = seed[7:0];
        peer_tx <= p;
        wr(16'hFF80, 8'h4B, 2'h0);
        wait_irq();
        rd(sync_serial_pkg::ADDR_STATUS, ok(8'h01));
        seed = lfsr(seed);
        peer_tx <= seed[7:0];
        rd(sync_serial_pkg::ADDR_SHIFT, ok(p));
        p = seed[7:0];
        wait_irq();
        rd(sync_serial_pkg::ADDR_STATUS, ok(8'h01));
        wr(16'hFF80, 8'h4B, 2'h0);
        quiet();
        wr(16'hFF80, 8'h0B, 2'h0);
        rd(sync_serial_pkg::ADDR_SHIFT, ok(p));
        // slave busy holds the start back until it signals ready
        peer_tx <= 8'hFF;
        busy <= 1'b1;
        wr(16'hFF80, 8'h8B, 2'h0);
        seed = lfsr(seed);
        d = seed[7:0];
        wr(sync_serial_pkg::ADDR_SHIFT, d, 2'h0);
        quiet();
        busy <= 1'b0;
        wait_irq();
        check(34'(peer_rx), 34'(d));
        rd(sync_serial_pkg::ADDR_STATUS, ok(8'h01));
        // three-wire lsb-first send: peer collects msb first, so reversed
        wr(16'hFF80, 8'h87, 2'h0);
        seed = lfsr(seed);
        d = seed[7:0];
        wr(sync_serial_pkg::ADDR_SHIFT, d, 2'h0);
        wait_irq();
        p = {<<{d}};
        check(34'(peer_rx), 34'(p));
        rd(sync_serial_pkg::ADDR_STATUS, ok(8'h01));
        wr(16'hFF80, 8'hAB, 2'h0);
        wr(sync_serial_pkg::ADDR_SHIFT, d, 2'h0);
        quiet();
        addr_frame <= 1'b1;
        wr(sync_serial_pkg::ADDR_SHIFT, d, 2'h0);
        wait_irq();
        check(34'(irq), 34'h1);
        wr(16'hFF80, 8'hAF, 2'h0);
        rd(16'hFF80, ok(8'hAB));
        wr(16'hFF80, 8'h88, 2'h0);
        check(34'({sck_oe, a_oe, b_oe}), 34'h2);
        wr(16'hFF80, 8'h9B, 2'h0);
        check(34'({sck_oe, a_oe, b_oe}), 34'h5);
        wr(16'hFF80, 8'h1B, 2'h0);
        check(34'({sck_oe, a_oe, b_oe}), 34'h4);
        rd(16'hFF94, {2'h2, 32'h0000_0000});
        wr(sync_serial_pkg::ADDR_VECTOR, 8'h00, 2'h2);
        rd(sync_serial_pkg::ADDR_VECTOR, {2'h0, 16'hFE30, 16'h0030});
        page <= 1'b1;
        rd(sync_serial_pkg::ADDR_VECTOR, {2'h0, 16'hFE30, 16'h8030});
        summarize();
    end
endmodule
